//--- logic/tws_fifo.sv
`timescale 1ns/1ps

module tws_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [AW:0] level
);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
        logic ov;
        logic [WIDTH-1:0] od;
    } tws_fq_type;

    tws_fq_type fq_ff;
    tws_fq_type nxt_fq;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic push;

    assign level = fq_ff.wp - fq_ff.rp;
    assign in_ready = (level < DEPTH[AW:0]);
    assign push = in_valid & in_ready;
    assign out_valid = fq_ff.ov;
    assign out_data = fq_ff.od;

    // registered output stage so the consumer sees flop outputs
    always_comb begin
        nxt_fq = fq_ff;
        if (push) begin
            nxt_fq.wp = fq_ff.wp + 1'b1;
        end
        if (!fq_ff.ov || out_ready) begin
            if (level != '0) begin
                nxt_fq.od = mem_ff[fq_ff.rp[AW-1:0]];
                nxt_fq.ov = 1'b1;
                nxt_fq.rp = fq_ff.rp + 1'b1;
            end else begin
                nxt_fq.ov = 1'b0;
            end
        end
        if (!reset_n) begin
            nxt_fq = '0;
        end
    end

    always_ff @(posedge clk) begin
        fq_ff <= nxt_fq;
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[fq_ff.wp[AW-1:0]] <= in_data;
        end
    end

endmodule

//--- logic/tws_pkg.sv
package tws_pkg;

    // slave identifiers, compared against address bits 7..4
    localparam logic [3:0] ID_MEM = 4'ha;
    localparam logic [3:0] ID_RTC = 4'hd;
    localparam int ID_HI = 7;
    localparam int ID_LO = 4;
    localparam int SEL_HI = 2;
    localparam int SEL_LO = 1;
    localparam int RW_BIT = 0;
    localparam int MSB_BIT = 7;
    localparam int MSB_NEXT = 6;

    // last legal register of the clock and supervisor target
    localparam logic [7:0] RTC_LAST_REG = 8'h18;

    // bit counting within a byte
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [3:0] CNT_LAST = 4'h7;
    localparam logic [3:0] CNT_FULL = 4'h8;

    // byte sent when no read data is waiting: all ones leaves sda released
    localparam logic [7:0] IDLE_BYTE = 8'hff;

    // positions in the filtered pin vector
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_SEL_LO = 2;
    localparam int PIN_SEL_HI = 3;
    localparam int PIN_SUP = 4;
    localparam int PIN_N = 5;

    // receive buffer shape
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    // one byte may still be in flight when the link sees room
    localparam logic [FIFO_AW:0] FIFO_ROOM_MAX = 5'h0e;

    typedef enum logic [0:0] {
        TGT_MEM = 1'b0,
        TGT_RTC = 1'b1
    } tws_tgt_type;

    typedef enum logic [2:0] {
        LK_IDLE = 3'b000,
        LK_ADDR = 3'b001,
        LK_ADDR_ACK = 3'b010,
        LK_WR_BYTE = 3'b011,
        LK_WR_ACK = 3'b100,
        LK_RD_BYTE = 3'b101,
        LK_RD_ACK = 3'b110
    } tws_lk_state_type;

    // one received write byte, tagged with its target
    typedef struct packed {
        tws_tgt_type target;
        logic first;
        logic [7:0] data;
    } tws_rx_type;

    localparam int RX_W = $bits(tws_rx_type);

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic [PIN_N-1:0] pin_s1;
        logic [PIN_N-1:0] pin_s2;
        logic [PIN_N-1:0] pin_s3;
        logic [PIN_N-1:0] flt;
        logic room_s1;
        logic room_s2;
        logic full_s1;
        logic full_s2;
        tws_lk_state_type state;
        logic [7:0] shift;
        logic [3:0] cnt;
        logic sda_oe;
        logic rw;
        tws_tgt_type target;
        logic first;
        logic acked;
        logic rx_tog;
        tws_rx_type rx_byte;
        logic take_tog;
    } tws_link_type;

    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        logic rx_s3;
        logic take_s1;
        logic take_s2;
        logic take_s3;
        logic room;
        logic [7:0] hold_data;
        logic hold_full;
        logic tx_ready;
    } tws_sys_type;

endpackage

//--- logic/tws_slave.sv
`timescale 1ns/1ps

module tws_slave
    import tws_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [1:0] dev_sel,
    input wire logic supply_trip_threshold,
    output logic rx_valid,
    input wire logic rx_ready,
    output tws_rx_type rx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data
);

    tws_link_type lk_ff;
    tws_link_type nxt_lk;
    tws_sys_type sy_ff;
    tws_sys_type nxt_sy;

    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [FIFO_AW:0] fifo_level;
    logic [RX_W-1:0] fifo_out;
    logic sda_pull_ff;

    function automatic logic id_hit(input logic [7:0] addr);
        id_hit = (addr[ID_HI:ID_LO] == ID_MEM) || (addr[ID_HI:ID_LO] == ID_RTC);
    endfunction

    function automatic tws_tgt_type id_target(input logic [7:0] addr);
        id_target = (addr[ID_HI:ID_LO] == ID_RTC) ? TGT_RTC : TGT_MEM;
    endfunction

    // ---------------- link domain ----------------
    logic scl_now;
    logic scl_was;
    logic sda_now;
    logic sda_was;
    logic start_ev;
    logic stop_ev;
    logic scl_rise;
    logic scl_fall;
    logic [1:0] sel_now;
    logic wr_bad;

    always_comb begin
        nxt_lk = lk_ff;
        nxt_lk.pin_s1 = {supply_trip_threshold, dev_sel, sda_i, scl_i};
        nxt_lk.pin_s2 = lk_ff.pin_s1;
        nxt_lk.pin_s3 = lk_ff.pin_s2;
        // a pin change counts once the second and third stages agree
        for (int i = 0; i < PIN_N; i++) begin
            if (lk_ff.pin_s2[i] == lk_ff.pin_s3[i]) begin
                nxt_lk.flt[i] = lk_ff.pin_s2[i];
            end
        end
        nxt_lk.room_s1 = sy_ff.room;
        nxt_lk.room_s2 = lk_ff.room_s1;
        nxt_lk.full_s1 = sy_ff.hold_full;
        nxt_lk.full_s2 = lk_ff.full_s1;

        scl_now = nxt_lk.flt[PIN_SCL];
        scl_was = lk_ff.flt[PIN_SCL];
        sda_now = nxt_lk.flt[PIN_SDA];
        sda_was = lk_ff.flt[PIN_SDA];
        sel_now = lk_ff.flt[PIN_SEL_HI:PIN_SEL_LO];
        start_ev = scl_now & scl_was & sda_was & ~sda_now;
        stop_ev = scl_now & scl_was & ~sda_was & sda_now;
        scl_rise = scl_now & ~scl_was;
        scl_fall = ~scl_now & scl_was;
        wr_bad = ~lk_ff.room_s2 |
                 ((lk_ff.target == TGT_RTC) && lk_ff.first && (lk_ff.shift > RTC_LAST_REG));

        case (lk_ff.state)
            LK_IDLE: begin
                // bits without a preceding start are ignored
                nxt_lk.sda_oe = 1'b0;
            end
            LK_ADDR: begin
                if (scl_rise) begin
                    nxt_lk.shift = {lk_ff.shift[MSB_NEXT:0], sda_now};
                    nxt_lk.cnt = lk_ff.cnt + CNT_ONE;
                end else if (scl_fall && lk_ff.cnt == CNT_FULL) begin
                    if (id_hit(lk_ff.shift) && lk_ff.shift[SEL_HI:SEL_LO] == sel_now) begin
                        nxt_lk.sda_oe = 1'b1;
                        nxt_lk.target = id_target(lk_ff.shift);
                        nxt_lk.rw = lk_ff.shift[RW_BIT];
                        nxt_lk.first = 1'b1;
                        nxt_lk.state = LK_ADDR_ACK;
                    end else begin
                        nxt_lk.state = LK_IDLE;
                    end
                end
            end
            LK_ADDR_ACK: begin
                if (scl_fall) begin
                    nxt_lk.cnt = CNT_ZERO;
                    if (lk_ff.rw) begin
                        // hold data is stable while its full flag is seen set
                        if (lk_ff.full_s2) begin
                            nxt_lk.shift = sy_ff.hold_data;
                            nxt_lk.take_tog = ~lk_ff.take_tog;
                        end else begin
                            nxt_lk.shift = IDLE_BYTE;
                        end
                        nxt_lk.sda_oe = ~nxt_lk.shift[MSB_BIT];
                        nxt_lk.state = LK_RD_BYTE;
                    end else begin
                        nxt_lk.sda_oe = 1'b0;
                        nxt_lk.state = LK_WR_BYTE;
                    end
                end
            end
            LK_WR_BYTE: begin
                if (scl_rise) begin
                    nxt_lk.shift = {lk_ff.shift[MSB_NEXT:0], sda_now};
                    nxt_lk.cnt = lk_ff.cnt + CNT_ONE;
                end else if (scl_fall && lk_ff.cnt == CNT_FULL) begin
                    if (wr_bad) begin
                        // leaving sda released is the nack; full buffer also nacks
                        nxt_lk.state = LK_IDLE;
                    end else begin
                        nxt_lk.rx_byte = '{target: lk_ff.target, first: lk_ff.first,
                                           data: lk_ff.shift};
                        nxt_lk.rx_tog = ~lk_ff.rx_tog;
                        nxt_lk.sda_oe = 1'b1;
                        nxt_lk.state = LK_WR_ACK;
                    end
                end
            end
            LK_WR_ACK: begin
                if (scl_fall) begin
                    nxt_lk.sda_oe = 1'b0;
                    nxt_lk.first = 1'b0;
                    nxt_lk.cnt = CNT_ZERO;
                    nxt_lk.state = LK_WR_BYTE;
                end
            end
            LK_RD_BYTE: begin
                if (scl_fall) begin
                    if (lk_ff.cnt == CNT_LAST) begin
                        nxt_lk.sda_oe = 1'b0;
                        nxt_lk.acked = 1'b0;
                        nxt_lk.state = LK_RD_ACK;
                    end else begin
                        nxt_lk.shift = {lk_ff.shift[MSB_NEXT:0], 1'b1};
                        nxt_lk.sda_oe = ~lk_ff.shift[MSB_NEXT];
                        nxt_lk.cnt = lk_ff.cnt + CNT_ONE;
                    end
                end
            end
            LK_RD_ACK: begin
                if (scl_rise) begin
                    nxt_lk.acked = ~sda_now;
                end else if (scl_fall) begin
                    if (lk_ff.acked) begin
                        nxt_lk.cnt = CNT_ZERO;
                        if (lk_ff.full_s2) begin
                            nxt_lk.shift = sy_ff.hold_data;
                            nxt_lk.take_tog = ~lk_ff.take_tog;
                        end else begin
                            nxt_lk.shift = IDLE_BYTE;
                        end
                        nxt_lk.sda_oe = ~nxt_lk.shift[MSB_BIT];
                        nxt_lk.state = LK_RD_BYTE;
                    end else begin
                        nxt_lk.state = LK_IDLE;
                    end
                end
            end
            default: begin
                nxt_lk.state = LK_IDLE;
            end
        endcase

        // aborts outrank any byte in progress
        if (nxt_lk.flt[PIN_SUP]) begin
            nxt_lk.state = LK_IDLE;
            nxt_lk.sda_oe = 1'b0;
        end else if (start_ev) begin
            nxt_lk.state = LK_ADDR;
            nxt_lk.cnt = CNT_ZERO;
            nxt_lk.sda_oe = 1'b0;
        end else if (stop_ev) begin
            nxt_lk.state = LK_IDLE;
            nxt_lk.sda_oe = 1'b0;
        end

        // reset is released into this domain through two stages
        if (!lk_ff.rst_s2) begin
            nxt_lk = '0;
        end
        nxt_lk.rst_s1 = reset_n;
        nxt_lk.rst_s2 = lk_ff.rst_s1;
    end

    always_ff @(posedge link_clk) begin
        lk_ff <= nxt_lk;
    end

    // the line is only ever pulled low: data stays zero, enable does the work
    always_ff @(posedge link_clk) begin
        sda_pull_ff <= 1'b0;
    end

    assign sda_o = sda_pull_ff;
    assign sda_oe = lk_ff.sda_oe;

    // ---------------- system domain ----------------
    always_comb begin
        nxt_sy = sy_ff;
        nxt_sy.rx_s1 = lk_ff.rx_tog;
        nxt_sy.rx_s2 = sy_ff.rx_s1;
        nxt_sy.rx_s3 = sy_ff.rx_s2;
        nxt_sy.take_s1 = lk_ff.take_tog;
        nxt_sy.take_s2 = sy_ff.take_s1;
        nxt_sy.take_s3 = sy_ff.take_s2;
        nxt_sy.room = (fifo_level < FIFO_ROOM_MAX);
        if (tx_valid && sy_ff.tx_ready) begin
            nxt_sy.hold_data = tx_data;
            nxt_sy.hold_full = 1'b1;
        end else if (sy_ff.take_s2 ^ sy_ff.take_s3) begin
            nxt_sy.hold_full = 1'b0;
        end
        nxt_sy.tx_ready = ~nxt_sy.hold_full;
        if (!reset_n) begin
            nxt_sy = '0;
        end
    end

    always_ff @(posedge clk) begin
        sy_ff <= nxt_sy;
    end

    assign tx_ready = sy_ff.tx_ready;
    // the link keeps rx_byte steady for a whole byte time after its toggle
    assign fifo_in_valid = (sy_ff.rx_s2 ^ sy_ff.rx_s3) & reset_n;

    tws_fifo #(
        .WIDTH(RX_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_rx_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(lk_ff.rx_byte),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    assign rx_data = tws_rx_type'(fifo_out);

endmodule

//--- verification/two_wire_slave_bus_conditions_tb.sv
`timescale 1ns/1ps
module two_wire_slave_bus_conditions_tb
    import tws_pkg::*;
;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    logic supply_trip_threshold = 1'b0;
    logic [1:0] dev_sel = 2'h0;
    logic rx_ready = 1'b0;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic hold_rx = 1'b1;
    logic scl, sda_pull, sda_o, sda_oe, rx_valid, tx_ready, ack;
    logic [7:0] rd, a_mem, a_rtc;
    logic [7:0] dq[$];
    logic [7:0] bad[3];
    tws_rx_type rx_data;
    tws_rx_type got[$];
    tws_rx_type exp_q[$];
    int err_total = 0;
    int cmp_count = 0;
    // pull-up wire: low while either side pulls
    wire sda = !sda_pull && !(sda_oe && !sda_o);
    always #2 clk = ~clk;
    initial begin
        #13;
        forever #40 link_clk = ~link_clk;
    end
    tws_slave dut_u (.clk(clk), .reset_n(reset_n), .link_clk(link_clk), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .dev_sel(dev_sel),
        .supply_trip_threshold(supply_trip_threshold), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data));
    tws_master master_u (.scl(scl), .sda_pull(sda_pull), .sda(sda));
    // record at the falling edge what the next rising edge takes; avoids the launch-edge race
    always @(negedge clk) begin
        logic r;
        r = !hold_rx && ($urandom_range(3) != 0);
        rx_ready <= r;
        if (reset_n && rx_valid && r) got.push_back(rx_data);
    end
    function automatic logic [7:0] sa(input logic [3:0] id, input logic rd_bit);
        sa = {id, 1'b0, dev_sel, rd_bit};
    endfunction
    function automatic logic acc(input logic [7:0] a);
        acc = (a[7:4] == 4'ha || a[7:4] == 4'hd) && a[2:1] == dev_sel;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        cmp_count++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %0h want %0h", $time, what, seen, want);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // bytes of dq from index n_ok on must be refused
    task automatic xfer(input logic [7:0] a, input int n_ok);
        tws_tgt_type t;
        t = a[7:4] == 4'hd ? TGT_RTC : TGT_MEM;
        master_u.bus_start();
        master_u.send_byte(a, ack);
        check(ack, acc(a), "address ack");
        foreach (dq[i]) begin
            master_u.send_byte(dq[i], ack);
            check(ack, i < n_ok, "data ack");
            if (i < n_ok) exp_q.push_back('{t, i == 0, dq[i]});
        end
        master_u.bus_stop();
        dq.delete();
    endtask
    task automatic drain();
        hold_rx = 1'b0;
        repeat (400) @(negedge clk);
        check(got.size(), exp_q.size(), "rx count");
        foreach (exp_q[i]) check(got[i], exp_q[i], "rx word");
        got.delete();
        exp_q.delete();
    endtask
    initial begin
        void'($urandom(32'h235e));
        dev_sel = 2'($urandom_range(3));
        a_mem = sa(4'ha, 1'b0);
        a_rtc = sa(4'hd, 1'b0);
        bad = '{sa(4'hb, 1'b0), sa(4'hc, 1'b0), {4'ha, 1'b0, ~dev_sel, 1'b0}};
        repeat (80) @(negedge clk);
        reset_n = 1'b1;
        repeat (200) @(negedge clk);
        // consumer stalled: output stage plus fourteen entries fit, the next one is refused
        repeat (16) dq.push_back(8'($urandom));
        xfer(a_mem, 15);
        drain();
        dq = '{8'h18, 8'($urandom)};
        xfer(a_rtc, 2);
        dq = '{8'h19};
        xfer(a_rtc, 0);
        foreach (bad[i]) xfer(bad[i], 0);
        @(negedge clk);
        tx_data = 8'($urandom);
        tx_valid = 1'b1;
        repeat (50) begin
            if (tx_ready === 1'b1) break;
            @(negedge clk);
        end
        @(negedge clk);
        tx_valid = 1'b0;
        check(tx_ready, 1'b0, "holding full");
        master_u.bus_start();
        master_u.send_byte(sa(4'ha, 1'b1), ack);
        check(ack, 1'b1, "read address");
        master_u.recv_byte(rd, 1'b1);
        check(rd, tx_data, "read byte");
        master_u.recv_byte(rd, 1'b0);
        check(rd, 8'hff, "empty holding");
        master_u.bus_stop();
        check(tx_ready, 1'b1, "holding freed");
        // start in mid-byte, then a new address is taken
        master_u.bus_start();
        master_u.send_byte(a_mem, ack);
        repeat (4) master_u.clk_bit(1'b0, ack);
        dq = '{8'h05};
        xfer(a_rtc, 1);
        master_u.bus_start();
        master_u.send_byte(a_mem, ack);
        repeat (4) master_u.clk_bit(1'b1, ack);
        master_u.bus_stop();
        master_u.send_byte(8'h3c, ack);
        check(ack, 1'b0, "byte after stop");
        master_u.bus_stop();
        master_u.bus_start();
        master_u.send_byte(a_mem, ack);
        @(negedge clk);
        supply_trip_threshold = 1'b1;
        master_u.send_byte(8'h5a, ack);
        check(ack, 1'b0, "low supply");
        @(negedge clk);
        supply_trip_threshold = 1'b0;
        master_u.send_byte(8'ha5, ack);
        check(ack, 1'b0, "no fresh start");
        master_u.bus_stop();
        dq = '{8'h77};
        xfer(a_mem, 1);
        drain();
        wrap_up();
    end
    initial begin
        #390us;
        err_total++;
        $display("CHECK FAILED at %0t: watchdog", $time);
        wrap_up();
    end
endmodule

//--- verification/tws_master.sv
`timescale 1ns/1ps
// bus master: owns scl, only pulls sda low or lets it float high
// quarter period: six link clocks per scl phase keeps the run short, filter takes four
module tws_master #(parameter int Q = 240) (
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // one scl pulse; b=1 releases sda so the slave may answer
    task automatic clk_bit(input logic b, output logic s);
        scl = 1'b0;
        #Q;
        sda_pull = !b;
        #Q;
        scl = 1'b1;
        #Q;
        s = sda;
        #Q;
        scl = 1'b0;
    endtask
    // sda edge while scl high; start leaves scl low, stop leaves it high
    task automatic cond(input logic p0);
        #Q;
        sda_pull = p0;
        #Q;
        scl = 1'b1;
        #Q;
        sda_pull = !p0;
        #Q;
        if (!p0) scl = 1'b0;
    endtask
    task automatic bus_start();
        cond(1'b0);
    endtask
    task automatic bus_stop();
        cond(1'b1);
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = !s;
    endtask
    task automatic recv_byte(output logic [7:0] d, input logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(!ack, s);
    endtask
endmodule

//--- verification/tws_slave_sva.sv
`timescale 1ns/1ps
module tws_slave_sva
    import tws_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic [1:0] dev_sel,
    input wire logic supply_trip_threshold,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire tws_rx_type rx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] tx_data
);
    chk_sda_low_only: assert property (@(posedge link_clk) disable iff (!reset_n)
        sda_o == 1'b0) else $error("sda output not low");
    chk_pull_scl_low: assert property (@(posedge link_clk) disable iff (!reset_n)
        $rose(sda_oe) |-> !scl_i) else $error("pull began with scl high");
    chk_free_scl_low: assert property (@(posedge link_clk) disable iff (!reset_n)
        $fell(sda_oe) && !supply_trip_threshold |-> !scl_i) else $error("release, scl high");
    chk_oe_hold_high: assert property (@(posedge link_clk) disable iff (!reset_n)
        scl_i && $past(scl_i) && !supply_trip_threshold |-> $stable(sda_oe))
        else $error("sda moved while scl high");
    chk_pull_ends: assert property (@(posedge link_clk) disable iff (!reset_n)
        $rose(sda_oe) |-> ##[1:150] !sda_oe) else $error("pull never released");
    chk_supply_abort: assert property (@(posedge link_clk) disable iff (!reset_n)
        supply_trip_threshold [*8] |-> !sda_oe) else $error("pull kept at low supply");
    chk_stop_idle: assert property (@(posedge link_clk) disable iff (!reset_n)
        scl_i && $past(scl_i) && $rose(sda_i) |-> !sda_oe [*8]) else $error("pull after stop");
    chk_rx_stands: assert property (@(posedge clk) disable iff (!reset_n)
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)) else $error("rx word moved");
    chk_tx_taken: assert property (@(posedge clk) disable iff (!reset_n)
        tx_valid && tx_ready |=> !tx_ready) else $error("tx byte not taken");
    cover property (@(posedge clk) rx_valid && rx_ready);
    cover property (@(posedge clk) tx_valid && tx_ready);
    cover property (@(posedge link_clk) $rose(sda_oe));
    cover property (@(posedge link_clk) $rose(supply_trip_threshold));
endmodule
bind tws_slave tws_slave_sva chk_u (.clk(clk), .reset_n(reset_n), .link_clk(link_clk),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .dev_sel(dev_sel),
    .supply_trip_threshold(supply_trip_threshold), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data));
